/* logic/uart_ctl_pkg.sv */
// Constants for the serial port interrupt, line format and modem control block.
// Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
package uart_ctl_pkg;
	// Register indices; byte address is four times the index
	localparam logic [2:0] IDX_DATA  = 3'h0;
	localparam logic [2:0] IDX_IER   = 3'h1;
	localparam logic [2:0] IDX_IDENT = 3'h2;
	localparam logic [2:0] IDX_LFC   = 3'h3;
	localparam logic [2:0] IDX_MLC   = 3'h4;
	localparam logic [2:0] IDX_LSR   = 3'h5;
	localparam logic [2:0] IDX_MSR   = 3'h6;
	localparam int         ADDR_W    = 5;

	// Line format fields
	localparam int LF_LEN_LO = 0;
	localparam int LF_STOP   = 2;
	localparam int LF_PEN    = 3;
	localparam int LF_EVEN   = 4;
	localparam int LF_STICK  = 5;
	localparam int LF_BREAK  = 6;
	localparam int LF_DIVISOR_LATCH_SELECT   = 7;

	// Modem control fields
	localparam int MC_DTR  = 0;
	localparam int MC_RTS  = 1;
	localparam int MC_GATE = 3;

	// Interrupt enable fields
	localparam int IE_RDA = 0;
	localparam int IE_THR = 1;
	localparam int IE_LSI = 2;
	localparam int IE_MSI = 3;

	// Identification codes, bits 3..0
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LSI  = 4'h6;
	localparam logic [3:0] ID_RDA  = 4'h4;
	localparam logic [3:0] ID_CTO  = 4'hC;
	localparam logic [3:0] ID_THR  = 4'h2;
	localparam logic [3:0] ID_MSI  = 4'h0;

	// Reset values
	localparam logic [7:0]  RST_LFC = 8'h00;
	localparam logic [7:0]  RST_MLC = 8'h00;
	localparam logic [3:0]  RST_IER = 4'h0;
	localparam logic [15:0] RST_DIV = 16'h0000;

	// Character times without traffic before a timeout
	localparam logic [2:0] CTO_CHARS = 3'h4;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_st_e;
endpackage

/* logic/uart_ident_format_ctl.sv */
// Interrupt identification, line format and modem control of one serial port.
// Assumes receive/transmit paths and status registers live in sibling logic.
//
// How it works
// RL1: Ident bit 0 reads low while an enabled interrupt pends, high otherwise.
// RL2: Ident bits 3..0 give highest pending source: 6, 4, C, 2, 0, none 1.
// RL3: Bit 3 zero without FIFOs; with FIFOs set alongside bit 2 on timeout.
// RL4: Ident bits 4 and 5 always read zero.
// RL5: Ident bits 7 and 6 read one while FIFO enable is set.
// RL6: Line status interrupt set by receive errors, cleared by line status read.
// RL7: Data available cleared by buffer read or level dropping below trigger.
// RL8: Timeout after four idle character times with data queued; buffer read clears.
// RL9: Transmit empty cleared by ident read naming it, or holding register write.
// RL10: Modem status interrupt set by modem input change, cleared by status read.
// RL11: Format bits 1..0 choose five to eight data bits.
// RL12: Bit 2 gives two stop bits, or one and a half for five bits.
// RL13: Receiver checks only the first stop bit.
// RL14: Bit 3 enables parity generation and checking after the data bits.
// RL15: Bit 4 clear means odd parity, set means even.
// RL16: Stick bit forces parity to inverse of bit 4.
// RL17: Bit 6 holds transmit output low until cleared.
// RL18: Bit 7 maps shared offsets onto the divisor latches.
// RL19: Terminal ready pin low when control bit 0 is set.
// RL20: Send request pin low when control bit 1 is set.
// RL21: Control bit 2 is plain storage with no pin.
// RL22: Control bit 3 clear floats the interrupt output; set enables it.
// RL23: Ident value is frozen for the whole host read.
`timescale 1ns/1ps
module uart_ident_format_ctl (
	// Clock and reset
	input  wire logic                          core_clk_in,
	input  wire logic                          srst_in,
	// Avalon-MM slave
	input  wire logic [uart_ctl_pkg::ADDR_W-1:0] avs_address_in,
	input  wire logic                          avs_read_in,
	input  wire logic                          avs_write_in,
	input  wire logic [31:0]                   avs_writedata_in,
	input  wire logic [3:0]                    avs_byteenable_in,
	output logic [31:0]                        avs_readdata_out,
	output logic                               avs_waitrequest_out,
	// From the rest of the port
	input  wire logic                          fifo_en_in,
	input  wire logic                          rx_err_event_in,
	input  wire logic                          rx_data_avail_in,
	input  wire logic                          rx_queue_nonempty_in,
	input  wire logic                          rx_push_in,
	input  wire logic                          char_tick_in,
	input  wire logic                          thr_empty_event_in,
	input  wire logic [7:0]                    tx_char_in,
	input  wire logic [7:0]                    rx_char_in,
	input  wire logic                          rx_parity_in,
	// Modem inputs, active low
	input  wire logic                          cts_n_in,
	input  wire logic                          dsr_n_in,
	input  wire logic                          ri_n_in,
	input  wire logic                          dcd_n_in,
	// Format to the serial paths
	output logic [3:0]                         data_bits_out,
	output logic                               stop_two_out,
	output logic                               stop_half_out,
	output logic                               parity_en_out,
	output logic                               tx_parity_bit_out,
	output logic                               rx_parity_err_out,
	output logic                               break_force_out,
	output logic [15:0]                        divisor_out,
	// Pins
	output logic                               terminal_ready_n_pin_out,
	output logic                               send_request_n_pin_out,
	output logic                               irq_out,
	output logic                               irq_oe_n_out
);
	import uart_ctl_pkg::*;

	// Parity bit for a character under the current format
	function automatic logic par_bit(input logic [7:0] ch, input logic [7:0] lf);
		logic [7:0] m;
		m = 8'hFF >> (2'd3 - lf[1:0]);
		if (lf[LF_STICK]) begin
			par_bit = ~lf[LF_EVEN]; // [RL16]
		end else begin
			par_bit = ^(ch & m) ^ ~lf[LF_EVEN]; // [RL15]
		end
	endfunction

	// Highest priority enabled source
	function automatic logic [3:0] ident(input logic lsi, input logic rda,
			input logic cto, input logic thr, input logic msi, input logic [3:0] ie);
		if (lsi && ie[IE_LSI]) ident = ID_LSI; // [RL2]
		else if (rda && ie[IE_RDA]) ident = ID_RDA;
		else if (cto && ie[IE_RDA]) ident = ID_CTO; // [RL3]
		else if (thr && ie[IE_THR]) ident = ID_THR;
		else if (msi && ie[IE_MSI]) ident = ID_MSI;
		else ident = ID_NONE; // [RL1]
	endfunction

	// Data bits per character, five to eight
	function automatic logic [3:0] char_len(input logic [7:0] lf);
		char_len = {2'b00, lf[LF_LEN_LO +: 2]} + 4'h5; // [RL11]
	endfunction

	// Format flags: two stops, one and a half stops, parity on, break
	function automatic logic [3:0] fmt_flags(input logic [7:0] lf);
		fmt_flags = {lf[LF_STOP] && lf[1:0] != 2'b00, lf[LF_STOP] && lf[1:0] == 2'b00,
			lf[LF_PEN], lf[LF_BREAK]}; // [RL12] [RL14] [RL17]
	endfunction

	// Active-low pin levels: terminal ready, send request, irq enable
	function automatic logic [2:0] pin_lvls(input logic [7:0] mc);
		pin_lvls = ~{mc[MC_DTR], mc[MC_RTS], mc[MC_GATE]}; // [RL19] [RL20] [RL22]
	endfunction

	bus_st_e     st_r, st_nxt;
	logic        wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0]  frz_id_r, frz_id_nxt;
	logic [7:0]  lfc_r, lfc_nxt;
	logic [7:0]  mlc_r, mlc_nxt;
	logic [3:0]  ier_r, ier_nxt;
	logic [15:0] div_r, div_nxt;
	logic        lsi_r, lsi_nxt;
	logic        cto_r, cto_nxt;
	logic        thr_r, thr_nxt;
	logic        msi_r, msi_nxt;
	logic [2:0]  idle_r, idle_nxt;
	logic [3:0]  modem_r, modem_nxt;
	logic        irq_r, irq_nxt;
	logic        txp_r, txp_nxt;
	logic        rxe_r, rxe_nxt;
	logic [3:0]  len_r, len_nxt;
	logic [3:0]  fmt_r, fmt_nxt;
	logic [2:0]  pin_r, pin_nxt;

	logic [2:0]  idx;
	logic        done;
	logic        rd_done;
	logic        wr_done;
	logic        divisor_latch_select;
	logic        rbr_rd;
	logic [3:0]  cur_id;
	logic [7:0]  ident_val;
	logic        pend_any;

	always_comb begin
		idx     = avs_address_in[ADDR_W-1:2];
		done    = (st_r == BUS_ACK);
		rd_done = done && avs_read_in;
		wr_done = done && avs_write_in && avs_byteenable_in[0];
		divisor_latch_select    = lfc_r[LF_DIVISOR_LATCH_SELECT];
		rbr_rd  = rd_done && idx == IDX_DATA && !divisor_latch_select;
		// Timeout only counts in FIFO mode, so bit 3 stays zero without FIFOs
		cur_id  = ident(lsi_r, rx_data_avail_in, cto_r && fifo_en_in, thr_r, msi_r,
			ier_r); // [RL3]
		ident_val = {fifo_en_in, fifo_en_in, 2'b00, cur_id}; // [RL4] [RL5]
		// Any enabled source, independent of the priority order
		pend_any = (lsi_r && ier_r[IE_LSI]) || (rx_data_avail_in && ier_r[IE_RDA]) ||
			(cto_r && fifo_en_in && ier_r[IE_RDA]) || (thr_r && ier_r[IE_THR]) ||
			(msi_r && ier_r[IE_MSI]); // [RL1]

		st_nxt    = st_r;
		wait_nxt  = 1'b1;
		rdata_nxt = rdata_r;
		frz_id_nxt = frz_id_r;
		lfc_nxt   = lfc_r;
		mlc_nxt   = mlc_r;
		ier_nxt   = ier_r;
		div_nxt   = div_r;

		// Bus: one wait cycle, answer at the second edge
		unique case (st_r)
			BUS_IDLE: begin
				if (avs_read_in || avs_write_in) begin
					st_nxt   = BUS_ACK;
					wait_nxt = 1'b0;
					frz_id_nxt = cur_id; // [RL23]
					rdata_nxt = 32'h0000_0000;
					if (avs_read_in) begin
						unique case (idx)
							IDX_DATA:  rdata_nxt[7:0] = divisor_latch_select ? div_r[7:0] : 8'h00;
							IDX_IER:   rdata_nxt[7:0] = divisor_latch_select ? div_r[15:8] : {4'h0, ier_r};
							IDX_IDENT: rdata_nxt[7:0] = ident_val; // [RL23]
							IDX_LFC:   rdata_nxt[7:0] = lfc_r;
							IDX_MLC:   rdata_nxt[7:0] = mlc_r; // [RL21]
							default:   rdata_nxt[7:0] = 8'h00;
						endcase
					end
				end
			end
			BUS_ACK: begin
				st_nxt = BUS_IDLE;
			end
		endcase

		if (wr_done) begin
			unique case (idx)
				IDX_DATA: if (divisor_latch_select) div_nxt[7:0] = avs_writedata_in[7:0]; // [RL18]
				IDX_IER: begin
					if (divisor_latch_select) div_nxt[15:8] = avs_writedata_in[7:0]; // [RL18]
					else ier_nxt = avs_writedata_in[3:0];
				end
				IDX_LFC: lfc_nxt = avs_writedata_in[7:0];
				IDX_MLC: mlc_nxt = {3'b000, avs_writedata_in[4:0]};
				default: ;
			endcase
		end

		// Outputs taken from the next state, so pins move with the write
		len_nxt = char_len(lfc_nxt); // [RL11]
		fmt_nxt = fmt_flags(lfc_nxt); // [RL12]
		pin_nxt = pin_lvls(mlc_nxt); // [RL19]

		// Sticky sources; a set in the clearing cycle wins
		lsi_nxt = rx_err_event_in ||
			(lsi_r && !(rd_done && idx == IDX_LSR)); // [RL6]
		thr_nxt = thr_empty_event_in || (thr_r &&
			!(wr_done && idx == IDX_DATA && !divisor_latch_select) &&
			!(rd_done && idx == IDX_IDENT && frz_id_r == ID_THR)); // [RL9]
		modem_nxt = {cts_n_in, dsr_n_in, ri_n_in, dcd_n_in};
		msi_nxt = (modem_nxt != modem_r) ||
			(msi_r && !(rd_done && idx == IDX_MSR)); // [RL10]

		// Idle character-time counter; traffic or empty queue restarts it
		idle_nxt = idle_r;
		if (!fifo_en_in || !rx_queue_nonempty_in || rx_push_in || rbr_rd) begin
			idle_nxt = 3'h0; // [RL8]
		end else if (char_tick_in && idle_r != CTO_CHARS) begin
			idle_nxt = idle_r + 3'h1;
		end
		cto_nxt = (idle_nxt == CTO_CHARS) && !rbr_rd; // [RL8]

		// Received data available is the level from the queue compare
		irq_nxt = (ident(lsi_nxt, rx_data_avail_in, cto_nxt, thr_nxt, msi_nxt,
			ier_nxt) != ID_NONE); // [RL7] [RL1]
		txp_nxt = par_bit(tx_char_in, lfc_r); // [RL14]
		rxe_nxt = lfc_r[LF_PEN] && (rx_parity_in != par_bit(rx_char_in, lfc_r)); // [RL14]
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			st_r     <= BUS_IDLE;
			wait_r   <= 1'b1;
			rdata_r  <= 32'h0000_0000;
			frz_id_r <= ID_NONE;
			lfc_r    <= RST_LFC;
			mlc_r    <= RST_MLC;
			ier_r    <= RST_IER;
			div_r    <= RST_DIV;
			lsi_r    <= 1'b0;
			cto_r    <= 1'b0;
			thr_r    <= 1'b0;
			msi_r    <= 1'b0;
			idle_r   <= 3'h0;
			modem_r  <= 4'hF;
			irq_r    <= 1'b0;
			txp_r    <= 1'b0;
			rxe_r    <= 1'b0;
			len_r    <= char_len(RST_LFC);
			fmt_r    <= fmt_flags(RST_LFC);
			pin_r    <= pin_lvls(RST_MLC);
		end else begin
			st_r     <= st_nxt;
			wait_r   <= wait_nxt;
			rdata_r  <= rdata_nxt;
			frz_id_r <= frz_id_nxt;
			lfc_r    <= lfc_nxt;
			mlc_r    <= mlc_nxt;
			ier_r    <= ier_nxt;
			div_r    <= div_nxt;
			lsi_r    <= lsi_nxt;
			cto_r    <= cto_nxt;
			thr_r    <= thr_nxt;
			msi_r    <= msi_nxt;
			idle_r   <= idle_nxt;
			modem_r  <= modem_nxt;
			irq_r    <= irq_nxt;
			txp_r    <= txp_nxt;
			rxe_r    <= rxe_nxt;
			len_r    <= len_nxt;
			fmt_r    <= fmt_nxt;
			pin_r    <= pin_nxt;
		end
	end

	// Every output leaves from its own flop; no decode glitches on pins
	always_comb begin
		avs_readdata_out    = rdata_r;
		avs_waitrequest_out = wait_r;
		data_bits_out  = len_r; // [RL11]
		stop_two_out   = fmt_r[3]; // [RL12]
		stop_half_out  = fmt_r[2]; // [RL12]
		// Stop bit count only shapes transmit; receive checks the first alone
		parity_en_out  = fmt_r[1]; // [RL13] [RL14]
		tx_parity_bit_out = txp_r;
		rx_parity_err_out = rxe_r;
		break_force_out = fmt_r[0]; // [RL17]
		divisor_out    = div_r;
		terminal_ready_n_pin_out = pin_r[2]; // [RL19]
		send_request_n_pin_out   = pin_r[1]; // [RL20]
		irq_out        = irq_r;
		irq_oe_n_out   = pin_r[0]; // [RL22]
	end

	// Checks
	sequence s_ident_read;
		st_r == BUS_IDLE && avs_read_in && idx == IDX_IDENT;
	endsequence

	a_ident_frozen: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL23]
		s_ident_read |=> !avs_waitrequest_out && avs_readdata_out[3:0] == $past(cur_id)
		##1 avs_waitrequest_out)
		else $error("ident not frozen");
	a_pending_low: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL1]
		s_ident_read |=> avs_readdata_out[0] == !$past(pend_any))
		else $error("pending bit wrong");
	a_fifo_bits: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL5]
		s_ident_read |=> avs_readdata_out[7:4] == ($past(fifo_en_in) ? 4'hC : 4'h0))
		else $error("ident high bits wrong");
	a_cto_fifo: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL3]
		cto_r |-> $past(fifo_en_in))
		else $error("timeout outside fifo mode");
	a_lsi_clear: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL6]
		rd_done && idx == IDX_LSR && !rx_err_event_in |=> !lsi_r)
		else $error("line status not cleared");
	a_thr_clear: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL9]
		wr_done && idx == IDX_DATA && !divisor_latch_select && !thr_empty_event_in |=> !thr_r)
		else $error("holding empty not cleared");
	a_msi_set: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL10]
		$changed({cts_n_in, dsr_n_in, ri_n_in, dcd_n_in}) |=> msi_r)
		else $error("modem change missed");
	a_dtr_pin: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL19]
		wr_done && idx == IDX_MLC |=> terminal_ready_n_pin_out == !$past(avs_writedata_in[0]))
		else $error("terminal ready pin wrong");
	a_irq_gate: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL22]
		wr_done && idx == IDX_MLC |=> irq_oe_n_out == !$past(avs_writedata_in[3]))
		else $error("irq gate wrong");
	a_break_hold: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL17]
		wr_done && idx == IDX_LFC && avs_writedata_in[6] |=> break_force_out)
		else $error("break not forced");
	a_break_clear: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL17]
		wr_done && idx == IDX_LFC && !avs_writedata_in[6] |=> !break_force_out)
		else $error("break not released");
	a_ident_zero: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL4]
		s_ident_read |=> avs_readdata_out[5:4] == 2'b00)
		else $error("ident bits 5 and 4 not zero");
	a_ident_bit3: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL3]
		s_ident_read |=> $past(fifo_en_in) || !avs_readdata_out[3])
		else $error("ident bit 3 set without fifo");
	a_cto_clear: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL8]
		rbr_rd |=> !cto_r)
		else $error("timeout not cleared by buffer read");
	a_cto_set: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL8]
		idle_r == CTO_CHARS - 3'h1 && char_tick_in && fifo_en_in && rx_queue_nonempty_in &&
		!rx_push_in && !rbr_rd |=> cto_r)
		else $error("timeout not raised");

	// Ident read while the holding-empty source is the one shown
	sequence s_thr_named;
		st_r == BUS_IDLE && avs_read_in && idx == IDX_IDENT && cur_id == ID_THR;
	endsequence

	a_thr_ident: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL9]
		s_thr_named ##1 !thr_empty_event_in |=> !thr_r)
		else $error("holding empty not cleared by ident read");
	a_msi_clear: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL10]
		rd_done && idx == IDX_MSR && $stable({cts_n_in, dsr_n_in, ri_n_in, dcd_n_in})
		|=> !msi_r)
		else $error("modem status not cleared");
	a_rts_pin: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL20]
		wr_done && idx == IDX_MLC |=> send_request_n_pin_out == !$past(avs_writedata_in[1]))
		else $error("send request pin wrong");
	a_len_field: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL11]
		wr_done && idx == IDX_LFC |=> data_bits_out == 4'h5 + $past(avs_writedata_in[1:0]))
		else $error("data length wrong");
	a_stop_count: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL12]
		wr_done && idx == IDX_LFC |=> stop_two_out ==
		($past(avs_writedata_in[2]) && $past(avs_writedata_in[1:0]) != 2'b00))
		else $error("stop count wrong");
	a_parity_off: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL14]
		!parity_en_out |=> !rx_parity_err_out)
		else $error("parity error with parity off");
	a_stick_tx: assert property (@(posedge core_clk_in) disable iff (srst_in) // [RL16]
		lfc_r[LF_PEN] && lfc_r[LF_STICK] |=> tx_parity_bit_out == !$past(lfc_r[LF_EVEN]))
		else $error("stick parity wrong");
endmodule

/* testbench/modem_peer.sv */
// Modem peer: pulls each status line low while its kick bit is held.
// Assumes kicks arrive from the bench just after rising clock edges.
`timescale 1ns/1ps
module modem_peer (
	// Clock and control
	input  wire logic       clk_in,
	input  wire logic [3:0] kick_in,
	// Status lines, active low
	output logic [3:0]      line_n_out
);
	logic [3:0] line_n_r = 4'hF;
	logic [3:0] line_n_nxt;
	// Idle high, so reset leaves no stale change flag
	always_comb line_n_nxt = ~kick_in;
	always_ff @(posedge clk_in) line_n_r <= line_n_nxt;
	assign line_n_out = line_n_r;
endmodule

/* testbench/uart_ident_format_ctl_bench.sv */
// Bench for the ident, line format and modem control block.
// Assumes the design package and the modem peer are compiled first.
`timescale 1ns/1ps
module uart_ident_format_ctl_bench;
	import uart_ctl_pkg::*;
	logic        core_clk_in = 1'b0, srst_in = 1'b1;
	logic [4:0]  avs_address_in = 5'h00;
	logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out;
	logic [3:0]  avs_byteenable_in = 4'hF, ev = 4'h0, kick = 4'h0;
	logic        avs_waitrequest_out, fifo_en_in = 1'b0, rx_data_avail_in = 1'b0;
	logic        rx_queue_nonempty_in = 1'b0, rx_parity_in = 1'b0;
	logic        rx_err_event_in, rx_push_in, char_tick_in, thr_empty_event_in;
	logic [7:0]  tx_char_in = 8'h00, rx_char_in = 8'h00, v;
	wire logic [3:0] mdm_n;
	logic [3:0]  data_bits_out;
	logic        stop_two_out, stop_half_out, parity_en_out, tx_parity_bit_out;
	logic        rx_parity_err_out, break_force_out, irq_out, irq_oe_n_out;
	logic        terminal_ready_n_pin_out, send_request_n_pin_out;
	logic [15:0] divisor_out, seed = 16'h12F9;
	int          error_cnt = 0, cmp_count = 0, cyc = 0;
	logic [31:0] expq[$];
	assign {rx_err_event_in, rx_push_in, char_tick_in, thr_empty_event_in} = ev;
	uart_ident_format_ctl uut (.core_clk_in, .srst_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .fifo_en_in, .rx_err_event_in, .rx_data_avail_in,
		.rx_queue_nonempty_in, .rx_push_in, .char_tick_in, .thr_empty_event_in,
		.tx_char_in, .rx_char_in, .rx_parity_in, .cts_n_in(mdm_n[3]),
		.dsr_n_in(mdm_n[2]), .ri_n_in(mdm_n[1]), .dcd_n_in(mdm_n[0]), .data_bits_out,
		.stop_two_out, .stop_half_out, .parity_en_out, .tx_parity_bit_out,
		.rx_parity_err_out, .break_force_out, .divisor_out, .terminal_ready_n_pin_out,
		.send_request_n_pin_out, .irq_out, .irq_oe_n_out);
	modem_peer peer (.clk_in(core_clk_in), .kick_in(kick), .line_n_out(mdm_n));
	always #5 core_clk_in = ~core_clk_in;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic par(input logic [7:0] f, input logic [7:0] c);
		return f[5] ? ~f[4] : ~f[4] ^ ^(c & ~(8'hE0 << f[1:0]));
	endfunction
	task automatic close_out;
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is seen low; no latency assumed
	task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d);
		@(posedge core_clk_in);
		avs_address_in <= {i, 2'b00};
		avs_read_in <= ~w;
		avs_write_in <= w;
		avs_writedata_in <= {24'h00_0000, d};
		do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] i, input logic [7:0] e);
		expq.push_back({24'h00_0000, e});
		bus(1'b0, i, 8'h00);
	endtask
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask
	task automatic pulse(input logic [3:0] p);
		@(posedge core_clk_in);
		ev <= p;
		@(posedge core_clk_in);
		ev <= 4'h0;
	endtask
	// Read data are valid only at the edge that sees waitrequest low
	always @(posedge core_clk_in) begin
		if (avs_read_in && avs_waitrequest_out === 1'b0)
			chk(avs_readdata_out, expq.pop_front());
	end
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out;
		end
	end
	initial begin
		repeat (6) @(posedge core_clk_in);
		srst_in <= 1'b0;
		@(posedge core_clk_in);
		chk({terminal_ready_n_pin_out, send_request_n_pin_out, irq_oe_n_out}, 3'h7);
		rd(IDX_LFC, RST_LFC);
		rd(IDX_MLC, RST_MLC);
		rd(3'h7, 8'h00);
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			v = {1'b0, seed[6:2], k[1:0]};
			wr(IDX_LFC, v);
			rd(IDX_LFC, v);
			chk(data_bits_out, 4'h5 + v[1:0]);
			chk({stop_two_out, stop_half_out}, {v[2] && v[1:0] != 0, v[2] && v[1:0] == 0});
			chk({parity_en_out, break_force_out}, {v[3], v[6]});
		end
		avs_byteenable_in <= 4'h0;
		wr(IDX_LFC, 8'h5A);
		avs_byteenable_in <= 4'hF;
		rd(IDX_LFC, v);
		for (int m = 0; m < 4; m++) begin
			v = {2'b00, m[1:0], 2'b10, m[1:0]};
			wr(IDX_LFC, v);
			repeat (4) begin
				seed = lfsr(seed);
				@(posedge core_clk_in);
				tx_char_in <= seed[7:0];
				rx_char_in <= seed[7:0];
				rx_parity_in <= seed[8];
				repeat (2) @(posedge core_clk_in);
				chk(tx_parity_bit_out, par(v, seed[7:0]));
				chk(rx_parity_err_out, seed[8] ^ par(v, seed[7:0]));
			end
		end
		wr(IDX_LFC, 8'h83);
		wr(IDX_DATA, seed[7:0]);
		wr(IDX_IER, seed[15:8]);
		rd(IDX_DATA, seed[7:0]);
		wr(IDX_LFC, 8'h03);
		wr(IDX_IER, 8'h0F);
		chk(divisor_out, seed);
		for (int i = 0; i < 16; i++) begin
			wr(IDX_MLC, i[7:0]);
			rd(IDX_MLC, i[7:0]);
			chk({terminal_ready_n_pin_out, send_request_n_pin_out, irq_oe_n_out},
				{~i[0], ~i[1], ~i[3]});
		end
		fifo_en_in <= 1'b1;
		rd(IDX_IDENT, 8'hC1);
		fork
			rd(IDX_IDENT, 8'hC1);
			pulse(4'h1);
		join
		chk(irq_out, 1'b1);
		rd(IDX_IDENT, 8'hC2);
		rd(IDX_IDENT, 8'hC1);
		pulse(4'h1);
		wr(IDX_DATA, 8'h00);
		rd(IDX_IDENT, 8'hC1);
		chk(irq_out, 1'b0);
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk_in);
			kick <= 4'h1 << k;
			repeat (2) @(posedge core_clk_in);
			kick <= 4'h0;
			// Slack for any input synchroniser
			repeat (6) @(posedge core_clk_in);
			rd(IDX_IDENT, 8'hC0);
			rd(IDX_MSR, 8'h00);
			rd(IDX_IDENT, 8'hC1);
		end
		pulse(4'h1);
		pulse(4'h8);
		rd(IDX_IDENT, 8'hC6);
		rd(IDX_LSR, 8'h00);
		rd(IDX_IDENT, 8'hC2);
		rd(IDX_IDENT, 8'hC1);
		rx_data_avail_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rd(IDX_IDENT, 8'hC4);
		rx_data_avail_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rd(IDX_IDENT, 8'hC1);
		rx_queue_nonempty_in <= 1'b1;
		repeat (3) pulse(4'h2);
		rd(IDX_IDENT, 8'hC1);
		pulse(4'h2);
		rd(IDX_IDENT, 8'hCC);
		rd(IDX_DATA, 8'h00);
		rx_queue_nonempty_in <= 1'b0;
		rd(IDX_IDENT, 8'hC1);
		fifo_en_in <= 1'b0;
		rd(IDX_IDENT, 8'h01);
		// Reset in mid-run must drop the pins back to inactive
		srst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		srst_in <= 1'b0;
		@(posedge core_clk_in);
		chk({terminal_ready_n_pin_out, send_request_n_pin_out, irq_oe_n_out}, 3'h7);
		rd(IDX_MLC, RST_MLC);
		close_out;
	end
endmodule
